// ### core/clk_ctl_pkg.sv
/*
 * Package for the system clock source and reset status controller:
 * register byte addresses, field layouts, reset values, source codes,
 * timing counts and the packed carriers used on the ports.
 * Assumes a plain one-cycle register port with 32-bit data.
 */
package clk_ctl_pkg;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [31:0] OSC_ADJUST_ADDR   = 32'h4004_8028;
   localparam logic [31:0] RESET_CAUSE_ADDR  = 32'h4004_8030;
   localparam logic [31:0] PLL_SELECT_ADDR   = 32'h4004_8040;
   localparam logic [31:0] PLL_COMMIT_ADDR   = 32'h4004_8044;
   localparam logic [31:0] MAIN_SELECT_ADDR  = 32'h4004_8070;
   localparam logic [31:0] MAIN_COMMIT_ADDR  = 32'h4004_8074;
   localparam logic [31:0] SYS_DIVIDER_ADDR  = 32'h4004_8078;
   localparam logic [31:0] PERIPH_GATES_ADDR = 32'h4004_8080;
   localparam logic [31:0] IRQ_STATUS_ADDR   = 32'h4004_80F0;
   localparam logic [31:0] IRQ_MASK_ADDR     = 32'h4004_80F4;

   // ---------------------------------------------------------------
   // field widths and reset values
   // ---------------------------------------------------------------
   localparam int          TRIM_W        = 8;
   localparam int          SEL_W         = 2;
   localparam int          DIV_W         = 8;
   localparam int          CAUSE_W       = 5;
   localparam int          IRQ_W         = 3;
   localparam int          COMMIT_BIT    = 0;
   localparam logic [7:0]  TRIM_RESET    = 8'h80;
   localparam logic [7:0]  DIV_RESET     = 8'h01;
   localparam logic [31:0] GATES_RESET   = 32'h0000_00DF;
   localparam logic [31:0] GATES_WMASK   = 32'h0106_7FFE;
   localparam int          ALWAYS_ON_BIT = 0;

   // reset cause bit positions
   localparam int CAUSE_POR  = 0;
   localparam int CAUSE_EXT  = 1;
   localparam int CAUSE_WDT  = 2;
   localparam int CAUSE_BOD  = 3;
   localparam int CAUSE_SOFT = 4;

   // interrupt status bit positions
   localparam int IRQ_PLL_APPLIED  = 0;
   localparam int IRQ_MAIN_APPLIED = 1;
   localparam int IRQ_CAUSE_SET    = 2;

   // ---------------------------------------------------------------
   // source codes
   // ---------------------------------------------------------------
   localparam logic [1:0] PLL_IN_IRC      = 2'h0;
   localparam logic [1:0] PLL_IN_CRYSTAL  = 2'h1;
   localparam logic [1:0] PLL_IN_RESERVED = 2'h2;
   localparam logic [1:0] PLL_IN_EXT_PIN  = 2'h3;
   localparam logic [1:0] MAIN_IRC        = 2'h0;
   localparam logic [1:0] MAIN_PLL_INPUT  = 2'h1;
   localparam logic [1:0] MAIN_WDT_OSC    = 2'h2;
   localparam logic [1:0] MAIN_PLL_OUTPUT = 2'h3;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;
   localparam int SWITCH_GAP_NS   = 20;
   localparam int SWITCH_GAP_CYC  =
      (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] SWITCH_GAP = 4'(SWITCH_GAP_CYC);

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   // reset source levels, high while that source holds reset
   typedef struct packed {
      logic software_reset_event;
      logic brownout_event;
      logic watchdog_event;
      logic external_pin_event;
      logic power_on;
   } reset_sources_t;

   typedef struct packed {
      logic [1:0] pll_input;
      logic [1:0] main_clock;
      logic       switching;
   } clock_select_t;

endpackage

// ### core/clk_source_ctl.sv
/*
 * System clock source and reset status controller. Holds the oscillator
 * trim, the sticky reset cause record, the PLL input and main clock
 * selectors with their zero-then-one commits, the system clock divider
 * and the always-on peripheral clock gate.
 * Assumes: a single-cycle register port whose read data is taken the
 * cycle after the read strobe; reset source levels synchronous to ref_clk.
 */
// The strobed register port was chosen for this implementation.
//
// Function
// RULE1: eight-bit oscillator trim in low byte, resets to 0x80, upper bits zero.
// RULE2: writing one clears a reset cause flag; writing zero leaves it.
// RULE3: power-on reset clears every other reset cause flag.
// RULE4: source still held when power-on ends gets its flag set.
// RULE5: flags: bit0 power-on, 1 pin, 2 watchdog, 3 brown-out, 4 software.
// RULE6: PLL input codes: 0 oscillator, 1 crystal, 3 pin, 2 reserved; reset 0.
// RULE7: PLL input change applies only on zero then one commit write.
// RULE8: PLL commit register is one bit at position 0, reset zero.
// RULE9: main clock codes: 0 oscillator, 1 PLL input, 2 watchdog, 3 PLL out.
// RULE10: main clock change applies only on zero then one commit write.
// RULE11: main commit register is one bit at position 0, reset zero.
// RULE12: system divider divides main clock by N, 1 to 255; resets to 1.
// RULE13: divider value zero stops the system clock entirely.
// RULE14: always-on system clock gate bit can never be disabled.
// RULE15: always-on gate bit is read-only, reads one, ignores writes.
// RULE16: commit is a rising edge of the stored bit; switching glitch-free.
//
`timescale 1ns/10ps

module clk_source_ctl (
   // clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        srst,
   // register port
   input  wire clk_ctl_pkg::bus_req_t       bus_req,
   output logic [31:0]                      rd_data,
   // reset source levels
   input  wire clk_ctl_pkg::reset_sources_t reset_sources,
   // clock control outputs
   output clk_ctl_pkg::clock_select_t       clock_select,
   output logic                             sys_clk_en,
   output logic [7:0]                       internal_osc_adjust,
   output logic [31:0]                      peripheral_clock_gates,
   // interrupt
   output logic                             irq
);

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [31:0] a,
                                input logic [31:0] off);
      hit = (a == off);
   endfunction

   wire logic [31:0] addr = bus_req.addr;
   wire logic [31:0] wdat = bus_req.wdata;
   wire logic        wr   = bus_req.wr;

   wire logic wr_trim  = wr & hit(addr, clk_ctl_pkg::OSC_ADJUST_ADDR);
   wire logic wr_cause = wr & hit(addr, clk_ctl_pkg::RESET_CAUSE_ADDR);
   wire logic wr_psel  = wr & hit(addr, clk_ctl_pkg::PLL_SELECT_ADDR);
   wire logic wr_pcom  = wr & hit(addr, clk_ctl_pkg::PLL_COMMIT_ADDR);
   wire logic wr_msel  = wr & hit(addr, clk_ctl_pkg::MAIN_SELECT_ADDR);
   wire logic wr_mcom  = wr & hit(addr, clk_ctl_pkg::MAIN_COMMIT_ADDR);
   wire logic wr_div   = wr & hit(addr, clk_ctl_pkg::SYS_DIVIDER_ADDR);
   wire logic wr_gates = wr & hit(addr, clk_ctl_pkg::PERIPH_GATES_ADDR);
   wire logic wr_istat = wr & hit(addr, clk_ctl_pkg::IRQ_STATUS_ADDR);
   wire logic wr_imask = wr & hit(addr, clk_ctl_pkg::IRQ_MASK_ADDR);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [7:0]  trim;
   logic [4:0]  cause;
   logic [4:0]  src_q;
   logic [1:0]  pll_pending;
   logic [1:0]  main_pending;
   logic        pll_commit;
   logic        main_commit;
   logic [1:0]  pll_active;
   logic [1:0]  main_active;
   logic [7:0]  divider;
   logic [7:0]  div_count;
   logic [3:0]  gap_count;
   logic [31:0] gates;
   logic [2:0]  irq_status;
   logic [2:0]  irq_mask;

   // ---------------------------------------------------------------
   // oscillator trim
   // ---------------------------------------------------------------
   // RULE1: trim byte store
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         trim <= clk_ctl_pkg::TRIM_RESET;
      end else if (wr_trim) begin
         trim <= wdat[7:0];
      end
   end

   // ---------------------------------------------------------------
   // reset cause record
   // ---------------------------------------------------------------
   wire logic [4:0] src_now = reset_sources;
   wire logic       por_now = src_now[clk_ctl_pkg::CAUSE_POR];
   wire logic       por_end = src_q[clk_ctl_pkg::CAUSE_POR] & ~por_now;

   // RULE4: sources held past power-on
   wire logic [4:0] held_set = por_end ? {src_now[4:1], 1'b0} : 5'h00;

   // RULE5: each source sets its own bit
   wire logic [4:0] edge_set = src_now & ~src_q;
   wire logic [4:0] cause_set = edge_set | held_set;

   // RULE2: write one clears, set wins
   wire logic [4:0] cause_clr = wr_cause ? wdat[4:0] : 5'h00;

   // RULE3: power-on wipes other causes
   wire logic [4:0] next_cause = por_now ? 5'h01 :
                                 (cause & ~cause_clr) | cause_set;

   wire logic cause_new = |(next_cause & ~cause);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cause <= 5'h00;
      end else begin
         cause <= next_cause;
      end
   end

   // history starts low, so a source held through srst counts as new
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         src_q <= 5'h00;
      end else begin
         src_q <= src_now;
      end
   end

   // ---------------------------------------------------------------
   // PLL input select and commit
   // ---------------------------------------------------------------
   // RULE16: rising edge of stored bit only
   wire logic pll_rise  = wr_pcom & wdat[clk_ctl_pkg::COMMIT_BIT] &
                          ~pll_commit;
   // RULE6: reserved code is never applied
   wire logic pll_legal = pll_pending != clk_ctl_pkg::PLL_IN_RESERVED;
   wire logic pll_apply = pll_rise & pll_legal;

   // RULE8: one commit bit, reset zero
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pll_commit <= 1'b0;
      end else if (wr_pcom) begin
         pll_commit <= wdat[clk_ctl_pkg::COMMIT_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pll_pending <= clk_ctl_pkg::PLL_IN_IRC;
      end else if (wr_psel) begin
         pll_pending <= wdat[1:0];
      end
   end

   // RULE7: apply on commit edge
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pll_active <= clk_ctl_pkg::PLL_IN_IRC;
      end else if (pll_apply) begin
         pll_active <= pll_pending;
      end
   end

   // ---------------------------------------------------------------
   // main clock select and commit
   // ---------------------------------------------------------------
   // RULE16: rising edge of stored bit only
   wire logic main_rise = wr_mcom & wdat[clk_ctl_pkg::COMMIT_BIT] &
                          ~main_commit;

   // RULE11: one commit bit, reset zero
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         main_commit <= 1'b0;
      end else if (wr_mcom) begin
         main_commit <= wdat[clk_ctl_pkg::COMMIT_BIT];
      end
   end

   // RULE9: two-bit main source code
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         main_pending <= clk_ctl_pkg::MAIN_IRC;
      end else if (wr_msel) begin
         main_pending <= wdat[1:0];
      end
   end

   // RULE10: apply on commit edge
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         main_active <= clk_ctl_pkg::MAIN_IRC;
      end else if (main_rise) begin
         main_active <= main_pending;
      end
   end

   // ---------------------------------------------------------------
   // switch gap
   // ---------------------------------------------------------------
   // the system enable is held low around a source change so that no
   // shortened pulse reaches the core while the mux settles
   wire logic switching = gap_count != 4'h0;

   // RULE16: quiet window around switch
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         gap_count <= 4'h0;
      end else if (main_rise | pll_apply) begin
         gap_count <= clk_ctl_pkg::SWITCH_GAP;
      end else if (switching) begin
         gap_count <= gap_count - 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // system clock divider
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         divider <= clk_ctl_pkg::DIV_RESET;
      end else if (wr_div) begin
         divider <= wdat[7:0];
      end
   end

   // RULE13: zero divider stops clock
   wire logic div_stop = divider == 8'h00;
   // a shrunk divider is caught by the compare, not missed by equality
   wire logic div_wrap = div_count >= (divider - 8'h01);
   wire logic [7:0] next_div_count = (div_stop | div_wrap) ? 8'h00 :
                                     div_count + 8'h01;

   // RULE12: one pulse every N cycles
   wire logic next_clk_en = ~div_stop & div_wrap & ~switching;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         div_count <= 8'h00;
      end else begin
         div_count <= next_div_count;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sys_clk_en <= 1'b0;
      end else begin
         sys_clk_en <= next_clk_en;
      end
   end

   // ---------------------------------------------------------------
   // peripheral clock gates
   // ---------------------------------------------------------------
   // RULE15: always-on bit ignores writes
   wire logic [31:0] gates_wr = wdat & clk_ctl_pkg::GATES_WMASK;
   // RULE14: always-on bit forced high
   wire logic [31:0] gates_on = 32'h0000_0001 << clk_ctl_pkg::ALWAYS_ON_BIT;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         gates <= clk_ctl_pkg::GATES_RESET;
      end else if (wr_gates) begin
         gates <= gates_wr | gates_on;
      end
   end

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   wire logic [2:0] irq_event = {cause_new, main_rise, pll_apply};
   wire logic [2:0] irq_clr   = wr_istat ? wdat[2:0] : 3'h0;
   // a new event in the clearing cycle survives the clear
   wire logic [2:0] next_irq_status = (irq_status & ~irq_clr) | irq_event;
   wire logic [2:0] next_irq_mask   = wr_imask ? wdat[2:0] : irq_mask;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_status <= 3'h0;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_mask <= 3'h0;
      end else begin
         irq_mask <= next_irq_mask;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_irq_status & next_irq_mask);
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   wire logic [31:0] rd_trim  = {24'h00_0000, trim};
   wire logic [31:0] rd_cause = {27'h0, cause};
   wire logic [31:0] rd_psel  = {30'h0, pll_pending};
   wire logic [31:0] rd_pcom  = {31'h0, pll_commit};
   wire logic [31:0] rd_msel  = {30'h0, main_pending};
   wire logic [31:0] rd_mcom  = {31'h0, main_commit};
   wire logic [31:0] rd_div   = {24'h00_0000, divider};
   wire logic [31:0] rd_istat = {29'h0, irq_status};
   wire logic [31:0] rd_imask = {29'h0, irq_mask};

   // unmapped addresses read as zero
   wire logic [31:0] next_rd_data =
      hit(addr, clk_ctl_pkg::OSC_ADJUST_ADDR)   ? rd_trim  :
      hit(addr, clk_ctl_pkg::RESET_CAUSE_ADDR)  ? rd_cause :
      hit(addr, clk_ctl_pkg::PLL_SELECT_ADDR)   ? rd_psel  :
      hit(addr, clk_ctl_pkg::PLL_COMMIT_ADDR)   ? rd_pcom  :
      hit(addr, clk_ctl_pkg::MAIN_SELECT_ADDR)  ? rd_msel  :
      hit(addr, clk_ctl_pkg::MAIN_COMMIT_ADDR)  ? rd_mcom  :
      hit(addr, clk_ctl_pkg::SYS_DIVIDER_ADDR)  ? rd_div   :
      hit(addr, clk_ctl_pkg::PERIPH_GATES_ADDR) ? gates    :
      hit(addr, clk_ctl_pkg::IRQ_STATUS_ADDR)   ? rd_istat :
      hit(addr, clk_ctl_pkg::IRQ_MASK_ADDR)     ? rd_imask :
      32'h0000_0000;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rd_data <= 32'h0000_0000;
      end else if (bus_req.rd) begin
         rd_data <= next_rd_data;
      end else begin
         rd_data <= 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         clock_select <= '0;
      end else begin
         clock_select.pll_input  <= pll_active;
         clock_select.main_clock <= main_active;
         clock_select.switching  <= switching;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         internal_osc_adjust    <= clk_ctl_pkg::TRIM_RESET;
         peripheral_clock_gates <= clk_ctl_pkg::GATES_RESET;
      end else begin
         internal_osc_adjust    <= trim;
         peripheral_clock_gates <= gates;
      end
   end

endmodule

// ### sim/clk_source_ctl_asserts.sv
/*
 * Checker for clk_source_ctl: commits, switch gap, divider pulses, trim and gate.
 * Assumes one ref_clk domain, srst synchronous and active high.
 */
`timescale 1ns/10ps

module clk_source_ctl_asserts (
   // clock and reset
   input wire logic                        ref_clk,
   input wire logic                        srst,
   // register port
   input wire clk_ctl_pkg::bus_req_t       bus_req,
   input wire logic [31:0]                 rd_data,
   input wire clk_ctl_pkg::reset_sources_t reset_sources,
   // clock control outputs
   input wire clk_ctl_pkg::clock_select_t  clock_select,
   input wire logic                        sys_clk_en,
   input wire logic [7:0]                  internal_osc_adjust,
   input wire logic [31:0]                 peripheral_clock_gates,
   input wire logic                        irq
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   // ------------------------------
   // shadows of software selections
   // ------------------------------
   logic [1:0] pll_sel;
   logic [1:0] main_sel;
   logic       pll_bit;
   logic       main_bit;
   logic [7:0] div_val;
   wire        wr_pll_sel  = bus_req.wr && bus_req.addr == clk_ctl_pkg::PLL_SELECT_ADDR;
   wire        wr_main_sel = bus_req.wr && bus_req.addr == clk_ctl_pkg::MAIN_SELECT_ADDR;
   wire        wr_pll_cm   = bus_req.wr && bus_req.addr == clk_ctl_pkg::PLL_COMMIT_ADDR;
   wire        wr_main_cm  = bus_req.wr && bus_req.addr == clk_ctl_pkg::MAIN_COMMIT_ADDR;
   wire        div_wr      = bus_req.wr && bus_req.addr == clk_ctl_pkg::SYS_DIVIDER_ADDR;
   // reserved code is held but a commit with it pending applies nothing
   wire        pll_go      = wr_pll_cm && bus_req.wdata[0] && !pll_bit && pll_sel != 2'h2;
   wire        main_go     = wr_main_cm && bus_req.wdata[0] && !main_bit;

   always_ff @(posedge ref_clk) begin
      pll_sel  <= srst ? 2'h0 : wr_pll_sel ? bus_req.wdata[1:0] : pll_sel;
      main_sel <= srst ? 2'h0 : wr_main_sel ? bus_req.wdata[1:0] : main_sel;
      pll_bit  <= srst ? 1'h0 : wr_pll_cm ? bus_req.wdata[0] : pll_bit;
      main_bit <= srst ? 1'h0 : wr_main_cm ? bus_req.wdata[0] : main_bit;
      div_val  <= srst ? 8'h01 : div_wr ? bus_req.wdata[7:0] : div_val;
   end

   sequence pll_commit_s;
      pll_go;
   endsequence

   sequence main_commit_s;
      main_go;
   endsequence

   a_pll_apply: assert property (pll_commit_s |-> ##2 clock_select.pll_input == $past(pll_sel, 2))
      else $error("pll input not applied after commit");
   a_pll_hold: assert property (!pll_go |-> ##2 $stable(clock_select.pll_input))
      else $error("pll input moved without commit");
   a_main_apply: assert property (main_commit_s |-> ##2 clock_select.main_clock == $past(main_sel, 2))
      else $error("main clock not applied after commit");
   a_main_hold: assert property (!main_go |-> ##2 $stable(clock_select.main_clock))
      else $error("main clock moved without commit");
   a_switch_gap: assert property ($rose(clock_select.switching) |->
      clock_select.switching[*2] ##1 !clock_select.switching)
      else $error("switch gap not two cycles");
   a_div_period: assert property (sys_clk_en && div_val > 8'h01 && !$past(div_wr) && !$past(div_wr, 2)
      |=> !sys_clk_en)
      else $error("divider pulses too close");
   a_div_stop: assert property (div_val == 8'h00 && $past(div_val) == 8'h00 |-> !sys_clk_en)
      else $error("system clock runs with divider zero");
   a_trim_read: assert property (bus_req.rd && bus_req.addr == clk_ctl_pkg::OSC_ADJUST_ADDR
      |=> rd_data == {24'h0, internal_osc_adjust})
      else $error("trim read differs from trim output");
   a_gate_on: assert property (peripheral_clock_gates[0])
      else $error("always-on gate dropped");
   a_gate_read: assert property (bus_req.rd && bus_req.addr == clk_ctl_pkg::PERIPH_GATES_ADDR |=> rd_data[0])
      else $error("always-on gate reads zero");
endmodule

bind clk_source_ctl clk_source_ctl_asserts clk_source_ctl_asserts_i (
   .ref_clk(ref_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data), .reset_sources(reset_sources),
   .clock_select(clock_select), .sys_clk_en(sys_clk_en), .internal_osc_adjust(internal_osc_adjust),
   .peripheral_clock_gates(peripheral_clock_gates), .irq(irq)
);

// ### sim/tb_clk_source_ctl.sv
/*
 * Directed bench for clk_source_ctl over its one-cycle register port.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/10ps

module tb_clk_source_ctl;
   logic                        ref_clk;
   logic                        srst;
   clk_ctl_pkg::bus_req_t       bus_req;
   logic [31:0]                 rd_data;
   clk_ctl_pkg::reset_sources_t reset_sources;
   clk_ctl_pkg::clock_select_t  clock_select;
   logic                        sys_clk_en;
   logic [7:0]                  internal_osc_adjust;
   logic [31:0]                 peripheral_clock_gates;
   logic                        irq;
   int                          error_cnt;
   int                          num_checks;
   int                          cycles;
   int                          pulses;
   logic [1:0]                  pll_exp;
   logic [31:0]                 rst_addr [8] = '{clk_ctl_pkg::OSC_ADJUST_ADDR, clk_ctl_pkg::RESET_CAUSE_ADDR,
      clk_ctl_pkg::PLL_SELECT_ADDR, clk_ctl_pkg::PLL_COMMIT_ADDR, clk_ctl_pkg::MAIN_SELECT_ADDR,
      clk_ctl_pkg::MAIN_COMMIT_ADDR, clk_ctl_pkg::SYS_DIVIDER_ADDR, 32'h4004_8000};
   logic [31:0]                 rst_val [8] = '{32'h80, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
   logic [1:0]                  pll_codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
   logic [7:0]                  divs [4] = '{8'h03, 8'h01, 8'h00, 8'hFF};

   clk_source_ctl clk_source_ctl_i (
      .ref_clk(ref_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data), .reset_sources(reset_sources),
      .clock_select(clock_select), .sys_clk_en(sys_clk_en), .internal_osc_adjust(internal_osc_adjust),
      .peripheral_clock_gates(peripheral_clock_gates), .irq(irq)
   );

   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ------------------------
   // register port and stimulus
   // ------------------------
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic reg_wr(input logic [31:0] addr, input logic [31:0] data);
      @(posedge ref_clk);
      bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [31:0] addr, input logic [31:0] exp);
      @(posedge ref_clk);
      bus_req <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      #1;
      check(rd_data, exp);
   endtask

   task automatic src(input logic [4:0] v);
      @(posedge ref_clk);
      reset_sources <= v;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 10000) begin
         error_cnt++;
         print_verdict();
      end
   end

   initial begin
      srst = 1'b1;
      bus_req = '0;
      reset_sources = '0;
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         reg_rd(rst_addr[i], rst_val[i]);
      end
      check(peripheral_clock_gates, clk_ctl_pkg::GATES_RESET);
      reg_wr(clk_ctl_pkg::OSC_ADJUST_ADDR, 32'hFFFF_FF5A);
      reg_rd(clk_ctl_pkg::OSC_ADJUST_ADDR, 32'h5A);
      check(internal_osc_adjust, 32'h5A);
      reg_wr(clk_ctl_pkg::PERIPH_GATES_ADDR, 32'h0);
      reg_rd(clk_ctl_pkg::PERIPH_GATES_ADDR, 32'h1);
      // watchdog flag first, then power-on while the pin is held
      reg_wr(clk_ctl_pkg::IRQ_MASK_ADDR, 32'h4);
      src(5'h04);
      src(5'h00);
      src(5'h03);
      wait_cyc(3);
      reg_rd(clk_ctl_pkg::RESET_CAUSE_ADDR, 32'h1);
      check(irq, 32'h1);
      src(5'h02);
      wait_cyc(3);
      reg_rd(clk_ctl_pkg::RESET_CAUSE_ADDR, 32'h3);
      src(5'h00);
      reg_wr(clk_ctl_pkg::RESET_CAUSE_ADDR, 32'h0);
      reg_rd(clk_ctl_pkg::RESET_CAUSE_ADDR, 32'h3);
      reg_wr(clk_ctl_pkg::RESET_CAUSE_ADDR, 32'hFFFF_FFFF);
      reg_rd(clk_ctl_pkg::RESET_CAUSE_ADDR, 32'h0);
      reg_wr(clk_ctl_pkg::IRQ_STATUS_ADDR, 32'h7);
      wait_cyc(2);
      check(irq, 32'h0);
      reg_wr(clk_ctl_pkg::IRQ_MASK_ADDR, 32'h0);
      for (int b = 2; b < 5; b++) begin
         src(5'(1 << b));
         src(5'h00);
         wait_cyc(2);
         reg_rd(clk_ctl_pkg::RESET_CAUSE_ADDR, 32'(1 << b));
         reg_wr(clk_ctl_pkg::RESET_CAUSE_ADDR, 32'(1 << b));
      end
      check(irq, 32'h0);
      reg_wr(clk_ctl_pkg::IRQ_MASK_ADDR, 32'h4);
      wait_cyc(2);
      check(irq, 32'h1);
      reg_wr(clk_ctl_pkg::IRQ_STATUS_ADDR, 32'h7);
      wait_cyc(2);
      check(irq, 32'h0);
      // commits kept apart so each switch gap stands alone
      pll_exp = 2'h0;
      for (int i = 0; i < 4; i++) begin
         reg_wr(clk_ctl_pkg::PLL_SELECT_ADDR, 32'(pll_codes[i]));
         reg_wr(clk_ctl_pkg::MAIN_SELECT_ADDR, 32'(3 - i));
         reg_rd(clk_ctl_pkg::PLL_SELECT_ADDR, 32'(pll_codes[i]));
         reg_rd(clk_ctl_pkg::MAIN_SELECT_ADDR, 32'(3 - i));
         reg_wr(clk_ctl_pkg::PLL_COMMIT_ADDR, 32'h0);
         reg_wr(clk_ctl_pkg::PLL_COMMIT_ADDR, 32'h1);
         wait_cyc(4);
         reg_wr(clk_ctl_pkg::MAIN_COMMIT_ADDR, 32'h0);
         reg_wr(clk_ctl_pkg::MAIN_COMMIT_ADDR, 32'h1);
         wait_cyc(4);
         if (pll_codes[i] != clk_ctl_pkg::PLL_IN_RESERVED) pll_exp = pll_codes[i];
         check(clock_select.pll_input, pll_exp);
         check(clock_select.main_clock, 32'(3 - i));
      end
      reg_wr(clk_ctl_pkg::MAIN_SELECT_ADDR, 32'h2);
      reg_wr(clk_ctl_pkg::MAIN_COMMIT_ADDR, 32'h1);
      wait_cyc(4);
      check(clock_select.main_clock, 32'h0);
      reg_rd(clk_ctl_pkg::MAIN_COMMIT_ADDR, 32'h1);
      reg_rd(clk_ctl_pkg::PLL_COMMIT_ADDR, 32'h1);
      // whole periods in each window give an exact pulse count
      for (int i = 0; i < 4; i++) begin
         reg_wr(clk_ctl_pkg::SYS_DIVIDER_ADDR, 32'(divs[i]));
         wait_cyc(4);
         pulses = 0;
         repeat ((divs[i] == 8'h00) ? 40 : 4 * divs[i]) begin
            wait_cyc(1);
            if (sys_clk_en === 1'b1) pulses++;
         end
         check(32'(pulses), (divs[i] == 8'h00) ? 32'h0 : 32'h4);
      end
      print_verdict();
   end
endmodule
